// >>> src/pmrv_cfg.svh
`ifndef PMRV_CFG_SVH
`define PMRV_CFG_SVH
// ==========================================
// Register addresses (page, register)
`define PMRV_PAGE_SEL_ADDR   8'h00
`define PMRV_ROUTE_PAGE      8'h00
`define PMRV_ROUTE_ADDR      8'h3f
`define PMRV_ANA_PAGE        8'h01
`define PMRV_DACVOL_ADDR     8'h23
`define PMRV_HPL_ADDR        8'h24
`define PMRV_HPR_ADDR        8'h25
`define PMRV_SPL_ADDR        8'h26
`define PMRV_SPR_ADDR        8'h27
// ==========================================
// Field positions
`define PMRV_LROUTE_LSB      4
`define PMRV_RROUTE_LSB      2
`define PMRV_SS_LSB          0
`define PMRV_DACL_EN_BIT     6
`define PMRV_DACR_EN_BIT     2
`define PMRV_AMP_EN_BIT      7
// ==========================================
// Reset values and codes
`define PMRV_REG_RST         8'h00
`define PMRV_MUTE_CODE       7'h7f
`define PMRV_LIN_LAST        7'h23
`define PMRV_TBL_LAST        7'h74
`define PMRV_FLOOR_ATT       10'h30f
`define PMRV_SS_BYPASS       2'h3
// ==========================================
// Timing
`define PMRV_MCLK_NS         20
`define PMRV_SS_STEP_NS      20000
`define PMRV_SS_STEP_CYC     ((`PMRV_SS_STEP_NS + `PMRV_MCLK_NS - 1) / `PMRV_MCLK_NS)
`endif

// >>> src/pmrv_pkg.sv
package pmrv_pkg;
   // ==========================================
   // Types
   typedef enum logic [1:0] {
      PMRV_RT_OFF,
      PMRV_RT_STRAIGHT,
      PMRV_RT_SWAP,
      PMRV_RT_MONO
   } pmrv_route_e;

   typedef struct packed {
      logic signed [15:0] l;
      logic signed [15:0] r;
   } pmrv_smp_s;

   typedef struct packed {
      logic       amp_en;
      logic       mute;
      logic [6:0] code;
      logic [9:0] att;
   } pmrv_vol_s;
endpackage

// >>> src/pmrv_top.sv
`include "pmrv_cfg.svh"
module pmrv_top
   import pmrv_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   output logic      [7:0]       reg_rdata_q,
   input  wire pmrv_smp_s        play_in,
   input  wire logic             play_vld,
   input  wire pmrv_smp_s        beep_in,
   output pmrv_smp_s             dac_q,
   output logic                  dac_vld_q,
   output logic                  dacl_to_vol_q,
   output logic                  dacr_to_vol_q,
   output pmrv_vol_s [3:0]       vol_q
);

   // ==========================================
   // Attenuation table, tenths of a dB
   // Codes 36 to 116 are irregular, so they are stored, not computed; higher codes take the floor value
   localparam logic [9:0] ATT_TBL [0:80] = '{
      10'd181, 10'd186, 10'd191, 10'd196, 10'd201, 10'd206, 10'd211, 10'd216, 10'd221, 10'd226,
      10'd231, 10'd236, 10'd241, 10'd246, 10'd251, 10'd256, 10'd261, 10'd266, 10'd271, 10'd276,
      10'd281, 10'd286, 10'd291, 10'd296, 10'd301, 10'd306, 10'd311, 10'd316, 10'd321, 10'd326,
      10'd331, 10'd336, 10'd341, 10'd346, 10'd352, 10'd357, 10'd362, 10'd367, 10'd372, 10'd377,
      10'd382, 10'd387, 10'd392, 10'd397, 10'd402, 10'd407, 10'd412, 10'd417, 10'd421, 10'd427,
      10'd432, 10'd438, 10'd443, 10'd448, 10'd452, 10'd458, 10'd462, 10'd467, 10'd474, 10'd479,
      10'd482, 10'd487, 10'd493, 10'd500, 10'd503, 10'd510, 10'd514, 10'd518, 10'd522, 10'd527,
      10'd537, 10'd542, 10'd553, 10'd567, 10'd583, 10'd602, 10'd627, 10'd643, 10'd662, 10'd687,
      10'd722
   };

   localparam logic [11:0] STEP_CYC = 12'(`PMRV_SS_STEP_CYC);

   // ==========================================
   // Functions

   // Register hit on the currently selected page
   function automatic logic reg_hit(input logic [7:0] page, input logic [7:0] addr,
                                    input logic [7:0] want_page, input logic [7:0] want_addr);
      reg_hit = (page == want_page) && (addr == want_addr);
   endfunction

   // Code to attenuation
   function automatic logic [9:0] att_of(input logic [6:0] code);
      logic [6:0] idx;
      idx = 7'(code - 7'(`PMRV_LIN_LAST) - 7'h01);
      if (code <= `PMRV_LIN_LAST)
         att_of = 10'(code) * 10'd5;
      else if (code > `PMRV_TBL_LAST)
         att_of = `PMRV_FLOOR_ATT;
      else
         att_of = ATT_TBL[idx];
   endfunction

   // Saturate a 17-bit sum to 16 bits
   function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
      if (v > 17'sd32767)
         sat16 = 16'sh7fff;
      else if (v < -17'sd32768)
         sat16 = 16'sh8000;
      else
         sat16 = v[15:0];
   endfunction

   // First-stage mixer: select or halved sum
   function automatic logic signed [15:0] mix1(input logic [1:0] rt, input logic signed [15:0] own,
                                               input logic signed [15:0] other);
      logic signed [16:0] sum;
      sum = 17'(own) + 17'(other);
      unique case (pmrv_route_e'(rt))
         PMRV_RT_OFF:      mix1 = 16'sh0000;
         PMRV_RT_STRAIGHT: mix1 = own;
         PMRV_RT_SWAP:     mix1 = other;
         PMRV_RT_MONO:     mix1 = sum[16:1];
      endcase
   endfunction

   // ==========================================
   // Register file
   logic [7:0] page_q;
   logic [7:0] route_q;
   logic [7:0] dacvol_q;
   logic [7:0] vreg_q [4];

   wire wr_page   = reg_wr && (reg_addr == `PMRV_PAGE_SEL_ADDR);
   wire wr_route  = reg_wr && reg_hit(page_q, reg_addr, `PMRV_ROUTE_PAGE, `PMRV_ROUTE_ADDR);
   wire wr_dacvol = reg_wr && reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_DACVOL_ADDR);
   wire [3:0] wr_vol;
   assign wr_vol[0] = reg_wr && reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_HPL_ADDR);
   assign wr_vol[1] = reg_wr && reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_HPR_ADDR);
   assign wr_vol[2] = reg_wr && reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_SPL_ADDR);
   assign wr_vol[3] = reg_wr && reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_SPR_ADDR);

   // Page select and the routing registers
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         page_q   <= `PMRV_REG_RST;
         route_q  <= `PMRV_REG_RST;
         dacvol_q <= `PMRV_REG_RST;
      end
      else
      begin
         if (wr_page)
            page_q <= reg_wdata;
         if (wr_route)
            route_q <= reg_wdata;
         if (wr_dacvol)
            dacvol_q <= reg_wdata;
      end
   end

   // Read mux: unmapped addresses read zero
   wire [7:0] rd_mux =
      (reg_addr == `PMRV_PAGE_SEL_ADDR) ? page_q :
      reg_hit(page_q, reg_addr, `PMRV_ROUTE_PAGE, `PMRV_ROUTE_ADDR) ? route_q :
      reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_DACVOL_ADDR) ? dacvol_q :
      reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_HPL_ADDR) ? vreg_q[0] :
      reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_HPR_ADDR) ? vreg_q[1] :
      reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_SPL_ADDR) ? vreg_q[2] :
      reg_hit(page_q, reg_addr, `PMRV_ANA_PAGE, `PMRV_SPR_ADDR) ? vreg_q[3] : 8'h00;

   // Read data lands one cycle after the strobe, then holds
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         reg_rdata_q <= 8'h00;
      else if (reg_rd)
         reg_rdata_q <= rd_mux;
   end

   // DAC to volume-control routing switches
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         dacl_to_vol_q <= 1'b0;
         dacr_to_vol_q <= 1'b0;
      end
      else
      begin
         dacl_to_vol_q <= dacvol_q[`PMRV_DACL_EN_BIT];
         dacr_to_vol_q <= dacvol_q[`PMRV_DACR_EN_BIT];
      end
   end

   // ==========================================
   // Digital mixers: two first-stage, two second-stage
   wire [1:0] rt_l = route_q[`PMRV_LROUTE_LSB +: 2];
   wire [1:0] rt_r = route_q[`PMRV_RROUTE_LSB +: 2];
   wire [1:0] ss_sel = route_q[`PMRV_SS_LSB +: 2];

   wire signed [15:0] m1_l = mix1(rt_l, play_in.l, play_in.r);
   wire signed [15:0] m1_r = mix1(rt_r, play_in.r, play_in.l);
   // Beep joins after playback scaling, so its level is independent
   wire signed [15:0] m2_l = sat16(17'(m1_l) + 17'(beep_in.l));
   wire signed [15:0] m2_r = sat16(17'(m1_r) + 17'(beep_in.r));

   // DAC input sample register, updated only on a valid sample
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         dac_q     <= '0;
         dac_vld_q <= 1'b0;
      end
      else
      begin
         dac_vld_q <= play_vld;
         if (play_vld)
         begin
            dac_q.l <= m2_l;
            dac_q.r <= m2_r;
         end
      end
   end

   // ==========================================
   // Analog volume controls: 0 HP left, 1 HP right, 2 SPK left, 3 SPK right
   // No power inputs gate this logic, so it runs with ADC and DAC down
   wire [11:0] step_last = 12'(STEP_CYC * 12'(ss_sel + 2'h1) - 12'h001);

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_vol
         logic [6:0]  cur_q;
         logic [11:0] cnt_q;
         wire  [6:0]  tgt    = vreg_q[g][6:0];
         wire         bypass = (ss_sel == `PMRV_SS_BYPASS);
         wire         tick   = (cnt_q == step_last);

         // Volume register of this channel
         always_ff @(posedge mclk)
         begin
            if (!rstn)
               vreg_q[g] <= `PMRV_REG_RST;
            else if (wr_vol[g])
               vreg_q[g] <= reg_wdata;
         end

         // Soft-step: one code per step period toward the target
         always_ff @(posedge mclk)
         begin
            if (!rstn)
            begin
               cur_q <= 7'h00;
               cnt_q <= 12'h000;
            end
            else if (bypass)
            begin
               cur_q <= tgt;
               cnt_q <= 12'h000;
            end
            else if (cur_q == tgt)
               cnt_q <= 12'h000;
            else if (tick)
            begin
               cnt_q <= 12'h000;
               cur_q <= (cur_q < tgt) ? 7'(cur_q + 7'h01) : 7'(cur_q - 7'h01);
            end
            else
               cnt_q <= 12'(cnt_q + 12'h001);
         end

         // Registered view of the channel for the analog side
         always_ff @(posedge mclk)
         begin
            if (!rstn)
               vol_q[g] <= '0;
            else
            begin
               vol_q[g].amp_en <= vreg_q[g][`PMRV_AMP_EN_BIT];
               vol_q[g].mute   <= !vreg_q[g][`PMRV_AMP_EN_BIT] && (tgt == `PMRV_MUTE_CODE);
               vol_q[g].code   <= cur_q;
               vol_q[g].att    <= att_of(cur_q);
            end
         end
      end
   endgenerate

   // ==========================================
   // Assertions
   property p_swap;
      @(posedge mclk) disable iff (!rstn)
      (play_vld && rt_l == 2'h2) |=> dac_q.l == sat16(17'($past(play_in.r)) + 17'($past(beep_in.l)));
   endproperty
   a_swap: assert property (p_swap) else $error("swap routing wrong");

   property p_mono;
      @(posedge mclk) disable iff (!rstn)
      (play_vld && rt_r == 2'h3) |=> dac_q.r ==
         sat16(17'(($past(17'(play_in.l)) + $past(17'(play_in.r))) >>> 1) + 17'($past(beep_in.r)));
   endproperty
   a_mono: assert property (p_mono) else $error("mono routing wrong");

   property p_off_beep;
      @(posedge mclk) disable iff (!rstn)
      (play_vld && rt_l == 2'h0) |=> dac_q.l == $past(beep_in.l) && dac_vld_q;
   endproperty
   a_off_beep: assert property (p_off_beep) else $error("beep path wrong");

   property p_bypass;
      @(posedge mclk) disable iff (!rstn)
      (wr_vol[0] && ss_sel == 2'h3 && !wr_route) ##1 (ss_sel == 2'h3)[*2]
         |=> vol_q[0].code == $past(vreg_q[0][6:0], 2);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass volume late");

   property p_step_one;
      @(posedge mclk) disable iff (!rstn)
      (ss_sel != 2'h3 && $past(ss_sel) != 2'h3 && $changed(vol_q[0].code)) |->
         (vol_q[0].code == 7'($past(vol_q[0].code) + 7'h01) || vol_q[0].code == 7'($past(vol_q[0].code) - 7'h01));
   endproperty
   a_step_one: assert property (p_step_one) else $error("volume jumped");

   property p_mute;
      @(posedge mclk) disable iff (!rstn)
      (vreg_q[3] == 8'h7f) |=> vol_q[3].mute && !vol_q[3].amp_en;
   endproperty
   a_mute: assert property (p_mute) else $error("mute missing");

   property p_floor;
      @(posedge mclk) disable iff (!rstn)
      (g_vol[3].cur_q >= 7'd117) |=> vol_q[3].att == 10'd783;
   endproperty
   a_floor: assert property (p_floor) else $error("floor gain wrong");

   property p_readback;
      @(posedge mclk) disable iff (!rstn)
      (reg_rd && !reg_wr && page_q == 8'h00 && reg_addr == 8'h3f) |=> reg_rdata_q == $past(route_q);
   endproperty
   a_readback: assert property (p_readback) else $error("route readback wrong");

   property p_hp_amp;
      @(posedge mclk) disable iff (!rstn)
      wr_vol[1] ##1 !wr_vol[1] |=> vol_q[1].amp_en == $past(reg_wdata[7], 2);
   endproperty
   a_hp_amp: assert property (p_hp_amp) else $error("amp enable wrong");

   property p_spk_amp;
      @(posedge mclk) disable iff (!rstn)
      wr_vol[2] ##1 !wr_vol[2] |=> vol_q[2].amp_en == $past(reg_wdata[7], 2);
   endproperty
   a_spk_amp: assert property (p_spk_amp) else $error("speaker amp enable wrong");

   property p_straight;
      @(posedge mclk) disable iff (!rstn)
      (play_vld && rt_r == 2'h1) |=> dac_q.r == sat16(17'($past(play_in.r)) + 17'($past(beep_in.r)));
   endproperty
   a_straight: assert property (p_straight) else $error("straight routing wrong");

   property p_mono_l;
      @(posedge mclk) disable iff (!rstn)
      (play_vld && rt_l == 2'h3) |=> dac_q.l ==
         sat16(17'(($past(17'(play_in.l)) + $past(17'(play_in.r))) >>> 1) + 17'($past(beep_in.l)));
   endproperty
   a_mono_l: assert property (p_mono_l) else $error("left mono routing wrong");

   // Switches lag the register by one cycle, so two after the write
   property p_dac_route;
      @(posedge mclk) disable iff (!rstn)
      wr_dacvol |=> ##1 (dacl_to_vol_q == $past(reg_wdata[6], 2) && dacr_to_vol_q == $past(reg_wdata[2], 2));
   endproperty
   a_dac_route: assert property (p_dac_route) else $error("dac routing switch wrong");

endmodule

// >>> dv/pmrv_host.sv
// ==========================================
// Host side: register accesses over the strobe port
module pmrv_host
(
   input  wire logic       mclk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus; clock and power are up before any tone traffic
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One write pulse; released lines flip so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   // One read pulse
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
   endtask
endmodule

// >>> dv/tb_playback_mix_route_volume.sv
// ==========================================
// Self-checking bench
module tb_playback_mix_route_volume
   import pmrv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic             mclk = 1'b0;
   logic             rstn = 1'b0;
   logic             reg_wr;
   logic             reg_rd;
   logic [7:0]       reg_addr;
   logic [7:0]       reg_wdata;
   logic [7:0]       reg_rdata_q;
   pmrv_smp_s        play_in = '0;
   logic             play_vld = 1'b0;
   pmrv_smp_s        beep_in = '0;
   pmrv_smp_s        dac_q;
   logic             dac_vld_q;
   logic             dacl_to_vol_q;
   logic             dacr_to_vol_q;
   pmrv_vol_s [3:0]  vol_q;
   int               n_fail = 0;
   int               n_compared = 0;
   int               cyc = 0;
   logic             rd_p = 1'b0;
   logic [31:0]      rq[$];
   logic [31:0]      dq[$];

   initial
   begin
      forever #10 mclk = ~mclk;
   end

   pmrv_host host_u (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   pmrv_top dut_u (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                   .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .play_in(play_in), .play_vld(play_vld),
                   .beep_in(beep_in), .dac_q(dac_q), .dac_vld_q(dac_vld_q), .dacl_to_vol_q(dacl_to_vol_q),
                   .dacr_to_vol_q(dacr_to_vol_q), .vol_q(vol_q));

   // ==========================================
   // Compare, report, close
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Result watcher; an empty queue yields unknown and so a mismatch
   always @(posedge mclk)
   begin
      if (rd_p)
         chk("rdata", {24'h0, reg_rdata_q}, rq.size() ? rq.pop_front() : 'x);
      if (dac_vld_q)
         chk("dac", dac_q, dq.size() ? dq.pop_front() : 'x);
      rd_p <= reg_rd;
   end

   // Hang guard, well above the ~7300 cycles the run needs
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         wrap_up();
      end
   end

   // ==========================================
   // Expected-value helpers
   function automatic int mixv(input logic [1:0] rt, input logic signed [15:0] own, input logic signed [15:0] oth);
      case (rt)
         2'd0: return 0;
         2'd1: return own;
         2'd2: return oth;
         default: return (int'(own) + int'(oth)) >>> 1;
      endcase
   endfunction

   function automatic logic [15:0] sat(input int v);
      if (v > 32767)
         return 16'h7fff;
      if (v < -32768)
         return 16'h8000;
      return v[15:0];
   endfunction

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back({24'h0, e});
      host_u.rd(a);
   endtask

   // One sample in; expectation noted before driving
   task automatic play(input logic [1:0] lr, input logic [1:0] rr);
      pmrv_smp_s s;
      pmrv_smp_s b;
      s = $urandom;
      b = $urandom;
      dq.push_back({sat(mixv(lr, s.l, s.r) + int'(b.l)), sat(mixv(rr, s.r, s.l) + int'(b.r))});
      @(posedge mclk);
      play_in <= s;
      beep_in <= b;
      play_vld <= 1'b1;
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      logic [7:0] d;
      logic [6:0] c;
      static int  codes[8] = '{0, 1, 35, 36, 101, 116, 117, 127};
      static int  atts[8] = '{0, 5, 175, 181, 510, 722, 783, 783};
      void'($urandom(36));
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      rd(8'h3f, 8'h00);
      chk("vol_rst", {31'h0, |vol_q}, 32'h0);
      host_u.wr(8'h3f, 8'h17);
      host_u.wr(8'h00, 8'h01);
      // Random read-back of every page-1 register
      for (int a = 8'h23; a <= 8'h27; a++)
      begin
         d = $urandom;
         host_u.wr(a[7:0], d);
         rd(a[7:0], d);
      end
      rd(8'h30, 8'h00);
      // Switches settle one cycle after the register, so wait two edges
      host_u.wr(8'h23, 8'h44);
      repeat (2) @(posedge mclk);
      chk("dac_route", {dacl_to_vol_q, dacr_to_vol_q}, 2'b11);
      host_u.wr(8'h23, 8'h40);
      repeat (2) @(posedge mclk);
      chk("dac_route", {dacl_to_vol_q, dacr_to_vol_q}, 2'b10);
      // Table points, soft-step bypassed, four channels at once
      for (int i = 0; i < 8; i++)
      begin
         c = codes[i][6:0];
         for (int k = 0; k < 4; k++)
            host_u.wr(8'h24 + k[7:0], {k[0] == 1'b0, c});
         repeat (3) @(posedge mclk);
         for (int k = 0; k < 4; k++)
         begin
            chk("code", vol_q[k].code, c);
            chk("att", vol_q[k].att, atts[i]);
            chk("amp", vol_q[k].amp_en, k[0] == 1'b0);
            chk("mute", vol_q[k].mute, k[0] == 1'b1 && c == 7'h7f);
         end
      end
      // Soft-stepping at 1x then 2x step length
      host_u.wr(8'h24, 8'h80);
      host_u.wr(8'h00, 8'h00);
      host_u.wr(8'h3f, 8'h14);
      host_u.wr(8'h00, 8'h01);
      host_u.wr(8'h24, 8'h82);
      repeat (990) @(posedge mclk);
      chk("step0", vol_q[0].code, 7'd0);
      repeat (20) @(posedge mclk);
      chk("step1", vol_q[0].code, 7'd1);
      repeat (1000) @(posedge mclk);
      chk("step2", vol_q[0].code, 7'd2);
      host_u.wr(8'h00, 8'h00);
      host_u.wr(8'h3f, 8'h15);
      host_u.wr(8'h00, 8'h01);
      host_u.wr(8'h24, 8'h83);
      repeat (1990) @(posedge mclk);
      chk("step2x", vol_q[0].code, 7'd2);
      repeat (20) @(posedge mclk);
      chk("step3", vol_q[0].code, 7'd3);
      // Third step length
      host_u.wr(8'h00, 8'h00);
      host_u.wr(8'h3f, 8'h16);
      host_u.wr(8'h00, 8'h01);
      host_u.wr(8'h24, 8'h84);
      repeat (2990) @(posedge mclk);
      chk("step3x", vol_q[0].code, 7'd3);
      repeat (20) @(posedge mclk);
      chk("step4", vol_q[0].code, 7'd4);
      // Every left/right route code: off, straight, swap, mono, plus tone
      host_u.wr(8'h00, 8'h00);
      for (int lr = 0; lr < 4; lr++)
      begin
         for (int rr = 0; rr < 4; rr++)
         begin
            host_u.wr(8'h3f, {2'b00, lr[1:0], rr[1:0], 2'b11});
            play(lr[1:0], rr[1:0]);
            play(lr[1:0], rr[1:0]);
            @(posedge mclk);
            play_vld <= 1'b0;
         end
      end
      repeat (5) @(posedge mclk);
      chk("left_rd", rq.size(), 0);
      chk("left_dac", dq.size(), 0);
      wrap_up();
   end
endmodule
